// ### rtl/record_input_router.sv
// Record input router: receivers and converter onto the input bus, sixteen input blocks,
// record bus to host and monitor, play bus from host, AXI4-Lite configuration.
// Assumes receiver words are held stable for a whole word clock period around its edge.
//
// How it works
// - Each digital input's recovered word clock and sample words are captured onto the input bus.
// - With the converter enabled, digital input samples are re-timed to the local frame first.
// - The expansion receiver supplies sixteen further input bus channels.
// - Sixteen input blocks each select any of the 32 input bus signals for one record channel.
// - Each block mutes and then dithers, with three algorithms and a choice of output depth.
// - The dither output is peak metered and is the block's record channel.
// - The sixteen record channels go to the host and to the output section.
// - Record channels pair as eight stereo devices, odd channel left and even channel right.
// - Host play device k fills play channel 2k-1 with left and 2k with right.
// - The play bus feeds the output section.
// - A restore command selects the internal clock, sets full level and clears all mutes.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "rir_defines.svh"
module record_input_router
  import rir_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [7:0] AES_WCLK,
  input wire bus16_type AES_SAMPLE,
  input wire logic EXP_WCLK,
  input wire bus16_type EXP_SAMPLE,
  input wire devices_type HOST_PLAY,
  input wire logic HOST_PLAY_VALID,
  output bus16_type REC_BUS,
  output logic REC_VALID,
  output devices_type REC_DEVICE,
  output bus16_type MON_REC_BUS,
  output bus16_type PLAY_BUS,
  output logic PLAY_VALID,
  output logic [2:0] CLK_SRC,
  output logic [7:0] OUT_LEVEL,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  state_type s_q;
  state_type s_d;
  logic tick;
  logic [8:0] edge_w;
  bus16_type blk_in;
  bus16_type blk_out;
  logic [15:0][23:0] mag;
  logic [15:0] peak_clr;
  logic [31:0] wd;
  logic [3:0] cidx;
  logic [3:0] ridx;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= `RIR_OFS_STATUS) || (a[7:6] == 2'b01) || (a[7:6] == 2'b10);
  endfunction

  function automatic logic [31:0] read_word(input state_type st, input logic [7:0] a);
    logic [3:0] k;
    read_word = '0;
    k = a[5:2];
    if (a == `RIR_OFS_CTRL) begin
      read_word[`RIR_CTRL_SRC_BIT] = st.src_en;
      read_word[`RIR_CTRL_CLK_LSB +: 3] = st.clk_src;
    end else if (a == `RIR_OFS_LEVEL) begin
      read_word[7:0] = st.level;
    end else if (a == `RIR_OFS_MUTE) begin
      read_word[15:0] = st.mute;
    end else if (a == `RIR_OFS_STATUS) begin
      read_word[8:0] = st.active;
    end else if (a[7:6] == 2'b01) begin
      read_word[`RIR_CFG_SEL_LSB +: 5] = st.cfg[k].sel;
      read_word[`RIR_CFG_ALG_LSB +: 2] = st.cfg[k].alg;
      read_word[`RIR_CFG_DEPTH_LSB +: 2] = st.cfg[k].depth;
    end else if (a[7:6] == 2'b10) begin
      read_word[23:0] = st.peak[k];
    end
  endfunction

  // Slower sample rate comes from a divider, as a one-cycle frame enable
  assign tick = (s_q.div == 10'(`RIR_FRAME_DIV - 1));
  // Only the second synchroniser stage and its delayed copy feed the edge detector
  assign edge_w = s_q.wclk_s2 & ~s_q.wclk_old;
  assign cidx = s_q.aw_addr[5:2];
  assign ridx = S_AXI_ARADDR[5:2];

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : gen_blk
      // Selector then mute, in that order, ahead of the dither stage
      assign blk_in[g] = s_q.mute[g] ? '0 : s_q.ibus[s_q.cfg[g].sel];
      record_dither u_dither (
        .in_sample(blk_in[g]),
        .alg(s_q.cfg[g].alg),
        .depth(s_q.cfg[g].depth),
        .noise_a(s_q.lfsr[g +: 16]),
        .noise_b(s_q.lfsr[(31 - g) -: 16]),
        .noise_p(s_q.lfsr_old[g +: 16]),
        .out_sample(blk_out[g])
      );
      assign mag[g] = blk_out[g][23] ? 24'(-blk_out[g]) : blk_out[g];
    end
    for (g = 0; g < 8; g++) begin : gen_dev
      assign REC_DEVICE[g].left = s_q.rec[2 * g];
      assign REC_DEVICE[g].right = s_q.rec[2 * g + 1];
    end
  endgenerate

  always_comb begin
    s_d = s_q;
    peak_clr = '0;
    wd = '0;
    s_d.div = tick ? 10'h000 : s_q.div + 10'h001;
    if (tick) begin
      s_d.lfsr_old = s_q.lfsr;
      s_d.lfsr = {s_q.lfsr[30:0], s_q.lfsr[31] ^ s_q.lfsr[21] ^ s_q.lfsr[1] ^ s_q.lfsr[0]};
    end
    s_d.wclk_s1 = {EXP_WCLK, AES_WCLK};
    s_d.wclk_s2 = s_q.wclk_s1;
    s_d.wclk_old = s_q.wclk_s2;
    s_d.data_s1 = {EXP_SAMPLE, AES_SAMPLE};
    s_d.data_s2 = s_q.data_s1;
    for (int i = 0; i < 9; i++) begin
      // A new word clock edge beats the frame clear of its activity flag
      if (tick) begin
        s_d.active[i] = 1'b0;
      end
      if (edge_w[i]) begin
        s_d.active[i] = 1'b1;
      end
    end
    for (int c = 0; c < 16; c++) begin
      if (edge_w[c / 2]) begin
        if (s_q.src_en) begin
          s_d.src_hold[c] = s_q.data_s2[c];
        end else begin
          s_d.ibus[c] = s_q.data_s2[c];
        end
      end
      // Converter is a sample-and-hold onto the local frame: no interpolation filter
      if (s_q.src_en && tick) begin
        s_d.ibus[c] = s_q.src_hold[c];
      end
      if (edge_w[8]) begin
        s_d.ibus[c + 16] = s_q.data_s2[c + 16];
      end
    end
    s_d.play_valid = HOST_PLAY_VALID;
    if (HOST_PLAY_VALID) begin
      for (int k = 0; k < 8; k++) begin
        s_d.play[2 * k] = HOST_PLAY[k].left;
        s_d.play[2 * k + 1] = HOST_PLAY[k].right;
      end
    end
    // Register bus: address and data held until both are present, then one write
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      s_d.w_full = 1'b1;
      s_d.w_data = S_AXI_WDATA;
      s_d.w_strb = S_AXI_WSTRB;
    end
    if (s_q.aw_full && s_q.w_full) begin
      for (int b = 0; b < 4; b++) begin
        wd[8 * b +: 8] = s_q.w_strb[b] ? s_q.w_data[8 * b +: 8]
                                      : 8'(read_word(s_q, s_q.aw_addr) >> (8 * b));
      end
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = mapped(s_q.aw_addr) ? `RIR_RESP_OKAY : `RIR_RESP_DECERR;
      if (s_q.aw_addr == `RIR_OFS_CTRL) begin
        s_d.src_en = wd[`RIR_CTRL_SRC_BIT];
        s_d.clk_src = wd[`RIR_CTRL_CLK_LSB +: 3];
        if (wd[`RIR_CTRL_RESTORE_BIT]) begin
          s_d.clk_src = `RIR_RST_CLK;
          s_d.level = `RIR_RST_LEVEL;
          s_d.mute = `RIR_RST_MUTE;
        end
      end else if (s_q.aw_addr == `RIR_OFS_LEVEL) begin
        s_d.level = wd[7:0];
      end else if (s_q.aw_addr == `RIR_OFS_MUTE) begin
        s_d.mute = wd[15:0];
      end else if (s_q.aw_addr[7:6] == 2'b01) begin
        s_d.cfg[cidx].sel = wd[`RIR_CFG_SEL_LSB +: 5];
        s_d.cfg[cidx].alg = dither_alg_type'(wd[`RIR_CFG_ALG_LSB +: 2]);
        s_d.cfg[cidx].depth = depth_type'(wd[`RIR_CFG_DEPTH_LSB +: 2]);
      end
    end
    if (s_q.bvalid && S_AXI_BREADY) begin
      s_d.bvalid = 1'b0;
    end
    case (s_q.rd)
      RD_IDLE: begin
        if (S_AXI_ARVALID) begin
          s_d.rd = RD_RESP;
          s_d.rdata = read_word(s_q, S_AXI_ARADDR);
          s_d.rresp = mapped(S_AXI_ARADDR) ? `RIR_RESP_OKAY : `RIR_RESP_DECERR;
          if (S_AXI_ARADDR[7:6] == 2'b10) begin
            peak_clr[ridx] = 1'b1;
          end
        end
      end
      RD_RESP: begin
        if (S_AXI_RREADY) begin
          s_d.rd = RD_IDLE;
        end
      end
      default: s_d.rd = RD_IDLE;
    endcase
    s_d.rec_valid = tick;
    for (int i = 0; i < 16; i++) begin
      // Clear on read; a frame arriving in the same cycle still lands its level
      s_d.peak[i] = peak_clr[i] ? 24'h000000 : s_q.peak[i];
      if (tick) begin
        s_d.rec[i] = blk_out[i];
        if (mag[i] > s_d.peak[i]) begin
          s_d.peak[i] = mag[i];
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s_q <= '0;
      s_q.level <= `RIR_RST_LEVEL;
      s_q.clk_src <= `RIR_RST_CLK;
      s_q.src_en <= `RIR_RST_SRC;
      s_q.mute <= `RIR_RST_MUTE;
      s_q.lfsr <= `RIR_RST_LFSR;
      s_q.rd <= RD_IDLE;
      for (int i = 0; i < 16; i++) begin
        s_q.cfg[i].sel <= 5'(i);
      end
    end else begin
      s_q <= s_d;
    end
  end

  assign REC_BUS = s_q.rec;
  assign REC_VALID = s_q.rec_valid;
  assign MON_REC_BUS = s_q.rec;
  assign PLAY_BUS = s_q.play;
  assign PLAY_VALID = s_q.play_valid;
  assign CLK_SRC = s_q.clk_src;
  assign OUT_LEVEL = s_q.level;
  assign S_AXI_AWREADY = !s_q.aw_full && !s_q.bvalid;
  assign S_AXI_WREADY = !s_q.w_full && !s_q.bvalid;
  assign S_AXI_BVALID = s_q.bvalid;
  assign S_AXI_BRESP = s_q.bresp;
  assign S_AXI_ARREADY = (s_q.rd == RD_IDLE);
  assign S_AXI_RVALID = (s_q.rd == RD_RESP);
  assign S_AXI_RDATA = s_q.rdata;
  assign S_AXI_RRESP = s_q.rresp;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  sequence s_wr_fire;
    s_q.aw_full && s_q.w_full;
  endsequence
  sequence s_restore;
    s_wr_fire ##0 (s_q.aw_addr == `RIR_OFS_CTRL && s_q.w_strb[0]
                   && s_q.w_data[`RIR_CTRL_RESTORE_BIT]);
  endsequence
  sequence s_cfg0_write;
    s_wr_fire ##0 (s_q.aw_addr == `RIR_OFS_CFG && s_q.w_strb[0]);
  endsequence

  property p_rx_direct;
    edge_w[0] && !s_q.src_en |=> s_q.ibus[1] == $past(s_q.data_s2[1]);
  endproperty
  a_rx_direct: assert property (p_rx_direct) else $error("receiver word not on input bus");

  property p_src_hold;
    s_q.src_en && !tick |=> s_q.ibus[0] == $past(s_q.ibus[0]);
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("converted input moved off frame");

  property p_exp;
    edge_w[8] |=> s_q.ibus[16] == $past(s_q.data_s2[16]);
  endproperty
  a_exp: assert property (p_exp) else $error("expansion word not on input bus");

  property p_select;
    tick |=> REC_VALID && REC_BUS[0] == $past(blk_out[0]);
  endproperty
  a_select: assert property (p_select) else $error("record channel not from its block");

  property p_mute;
    tick && s_q.mute[1] && s_q.cfg[1].alg == ALG_OFF |=> REC_BUS[1] == '0;
  endproperty
  a_mute: assert property (p_mute) else $error("muted block not silent");

  property p_peak;
    tick |=> s_q.peak[2] >= $past(mag[2]) && REC_BUS[2] == $past(blk_out[2]);
  endproperty
  a_peak: assert property (p_peak) else $error("peak below dithered level");

  property p_monitor;
    MON_REC_BUS == REC_BUS;
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor copy differs");

  property p_stereo;
    REC_DEVICE[0].left == REC_BUS[0] && REC_DEVICE[7].right == REC_BUS[15];
  endproperty
  a_stereo: assert property (p_stereo) else $error("record device pairing wrong");

  property p_play;
    HOST_PLAY_VALID |=> PLAY_VALID && PLAY_BUS[1] == $past(HOST_PLAY[0].right);
  endproperty
  a_play: assert property (p_play) else $error("play bus mapping wrong");

  property p_restore;
    s_restore |=> CLK_SRC == `RIR_RST_CLK && OUT_LEVEL == `RIR_RST_LEVEL && s_q.mute == '0;
  endproperty
  a_restore: assert property (p_restore) else $error("restore defaults incomplete");

  property p_cfg_apply;
    s_cfg0_write |=> s_q.cfg[0].sel == $past(s_q.w_data[4:0]) ##0 S_AXI_BVALID;
  endproperty
  a_cfg_apply: assert property (p_cfg_apply) else $error("block setting not stored");

  property p_frame;
    REC_VALID |=> !REC_VALID [*8];
  endproperty
  a_frame: assert property (p_frame) else $error("frames too close");
endmodule

// ### rtl/rir_defines.svh
// Constants of the record input router: timing, register offsets, field positions, resets.
// Assumes a 25 MHz reference clock and byte addressing on an 8-bit AXI4-Lite window.
`ifndef RIR_DEFINES_SVH
`define RIR_DEFINES_SVH

`define RIR_REF_HZ 25000000
`define RIR_FS_HZ 48000
`define RIR_FRAME_DIV (`RIR_REF_HZ / `RIR_FS_HZ)

`define RIR_OFS_CTRL 8'h00
`define RIR_OFS_LEVEL 8'h04
`define RIR_OFS_MUTE 8'h08
`define RIR_OFS_STATUS 8'h0C
`define RIR_OFS_CFG 8'h40
`define RIR_OFS_PEAK 8'h80

`define RIR_CTRL_SRC_BIT 0
`define RIR_CTRL_RESTORE_BIT 1
`define RIR_CTRL_CLK_LSB 4
`define RIR_CFG_SEL_LSB 0
`define RIR_CFG_ALG_LSB 8
`define RIR_CFG_DEPTH_LSB 12

`define RIR_RST_LEVEL 8'hFF
`define RIR_RST_CLK 3'h0
`define RIR_RST_SRC 1'b0
`define RIR_RST_MUTE 16'h0000
`define RIR_RST_LFSR 32'h00000001

`define RIR_RESP_OKAY 2'b00
`define RIR_RESP_DECERR 2'b11

`endif

// ### rtl/rir_pkg.sv
// Types shared by the record input router and its dither stage.
// Assumes 24-bit signed audio samples throughout.
package rir_pkg;
  typedef logic signed [23:0] sample_type;
  typedef sample_type [15:0] bus16_type;
  typedef sample_type [31:0] bus32_type;
  typedef enum logic [1:0] {
    ALG_OFF = 2'h0, ALG_RECT = 2'h1, ALG_TRI = 2'h2, ALG_HIPASS = 2'h3
  } dither_alg_type;
  typedef enum logic [1:0] {
    DEPTH_24 = 2'h0, DEPTH_20 = 2'h1, DEPTH_16 = 2'h2, DEPTH_RSV = 2'h3
  } depth_type;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} rd_state_type;
  typedef struct packed {
    logic [4:0] sel;
    dither_alg_type alg;
    depth_type depth;
  } cfg_type;
  typedef struct packed {
    sample_type left;
    sample_type right;
  } stereo_type;
  typedef stereo_type [7:0] devices_type;
  typedef struct packed {
    logic [8:0] wclk_s1;
    logic [8:0] wclk_s2;
    logic [8:0] wclk_old;
    bus32_type data_s1;
    bus32_type data_s2;
    bus32_type ibus;
    bus16_type src_hold;
    bus16_type rec;
    logic rec_valid;
    logic [15:0][23:0] peak;
    cfg_type [15:0] cfg;
    logic [15:0] mute;
    logic src_en;
    logic [2:0] clk_src;
    logic [7:0] level;
    logic [8:0] active;
    logic [9:0] div;
    logic [31:0] lfsr;
    logic [31:0] lfsr_old;
    bus16_type play;
    logic play_valid;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    rd_state_type rd;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_type;
endpackage

// ### rtl/record_dither.sv
// One dither stage: adds the chosen noise, saturates and truncates to the chosen depth.
// Assumes the caller supplies fresh noise words once per frame; purely combinational.
`timescale 1ns/100ps
module record_dither
  import rir_pkg::*;
(
  input wire sample_type in_sample,
  input wire dither_alg_type alg,
  input wire depth_type depth,
  input wire logic [15:0] noise_a,
  input wire logic [15:0] noise_b,
  input wire logic [15:0] noise_p,
  output sample_type out_sample
);
  logic [3:0] shift;
  logic [23:0] lsb_mask;
  logic signed [25:0] na;
  logic signed [25:0] nb;
  logic signed [25:0] np;
  logic signed [25:0] noise;
  logic signed [25:0] sum;
  sample_type sat;

  always_comb begin
    case (depth)
      DEPTH_20: shift = 4'h4;
      DEPTH_16: shift = 4'h8;
      default: shift = 4'h0;
    endcase
    lsb_mask = (24'h000001 << shift) - 24'h000001;
    na = $signed({10'h000, noise_a & lsb_mask[15:0]});
    nb = $signed({10'h000, noise_b & lsb_mask[15:0]});
    np = $signed({10'h000, noise_p & lsb_mask[15:0]});
    case (alg)
      ALG_RECT: noise = na;
      ALG_TRI: noise = na + nb - $signed({2'b00, lsb_mask});
      // First difference of white noise pushes the dither energy upward in frequency
      ALG_HIPASS: noise = na - np;
      default: noise = '0;
    endcase
    sum = $signed({{2{in_sample[23]}}, in_sample}) + noise;
    if (sum[25] && (sum[24:23] != 2'b11)) begin
      sat = 24'h800000;
    end else if (!sum[25] && (sum[24:23] != 2'b00)) begin
      sat = 24'h7FFFFF;
    end else begin
      sat = sum[23:0];
    end
    out_sample = sat & ~lsb_mask;
  end
endmodule

// ### verif/rx_model.sv
// Receiver model: digital inputs and expansion receiver feeding the router.
// Assumes the bench sets the sample values; words change only on a falling word clock.
`timescale 1ns/100ps
module rx_model
  import rir_pkg::*;
(
  input wire bus16_type aes_val,
  input wire bus16_type exp_val,
  output logic [7:0] wclk,
  output bus16_type aes,
  output logic ewclk,
  output bus16_type ex_out
);
  // Half period off the reference grid, so the edges drift against it
  initial begin
    wclk = 8'h00;
    ewclk = 1'b0;
    aes = '0;
    ex_out = '0;
    forever begin
      #8003;
      wclk = ~wclk;
      ewclk = ~ewclk;
      if (!ewclk) begin
        aes = aes_val;
        ex_out = exp_val;
      end
    end
  end
endmodule

// ### verif/tb_record_input_router.sv
// Self-checking bench for the record input router: registers, input blocks, play bus.
// Assumes the receiver model in rx_model.sv and a 25 MHz reference clock.
`timescale 1ns/100ps
`include "rir_defines.svh"
module tb_record_input_router
  import rir_pkg::*;
;
  logic REF_CLK, RST, EXP_WCLK, HOST_PLAY_VALID, REC_VALID, PLAY_VALID;
  logic [7:0] AES_WCLK, OUT_LEVEL;
  bus16_type AES_SAMPLE, EXP_SAMPLE, REC_BUS, MON_REC_BUS, PLAY_BUS, aes_v, exp_v;
  devices_type HOST_PLAY, REC_DEVICE;
  logic [2:0] CLK_SRC;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  int fail_count = 0;
  int compares = 0;
  int seed = 32'hCD93B4FC;
  int gap;

  record_input_router dut (.REF_CLK, .RST, .AES_WCLK, .AES_SAMPLE, .EXP_WCLK, .EXP_SAMPLE,
    .HOST_PLAY, .HOST_PLAY_VALID, .REC_BUS, .REC_VALID, .REC_DEVICE, .MON_REC_BUS, .PLAY_BUS,
    .PLAY_VALID, .CLK_SRC, .OUT_LEVEL, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY);
  rx_model model (.aes_val(aes_v), .exp_val(exp_v), .wclk(AES_WCLK), .aes(AES_SAMPLE),
    .ewclk(EXP_WCLK), .ex_out(EXP_SAMPLE));

  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] want);
    compares++;
    if (seen !== want) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic timed_out(string what);
    fail_count++;
    $display("mismatch %s expected answer seen timeout", what);
    report_and_stop();
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] want);
    int n;
    @(posedge REF_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WDATA <= d;
    S_AXI_WSTRB <= 4'hF;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge REF_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID) break;
    end
    if (n == 50) timed_out("write response");
    check("write resp", S_AXI_BRESP, want);
    S_AXI_BREADY <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] want, logic [1:0] wresp, bit at_least = 1'b0);
    int n;
    @(posedge REF_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge REF_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID) break;
    end
    if (n == 50) timed_out("read response");
    if (at_least) check("peak floor", 32'(S_AXI_RDATA >= want), 32'h1);
    else check("read data", S_AXI_RDATA, want);
    check("read resp", S_AXI_RRESP, wresp);
    S_AXI_RREADY <= 1'b0;
  endtask

  task automatic wait_frame(int k);
    int n;
    repeat (k) begin
      for (n = 0; n < 600; n++) begin
        @(posedge REF_CLK);
        if (REC_VALID === 1'b1) break;
      end
      if (n == 600) timed_out("frame");
      gap = n + 1;
    end
  endtask

  function automatic sample_type expect_rec(sample_type s, logic m, depth_type d);
    if (m) return '0;
    if (d == DEPTH_20) return s & ~24'h00000F;
    if (d == DEPTH_16) return s & ~24'h0000FF;
    return s;
  endfunction

  // One pass of random patching; with dither on only the truncation is predictable
  task automatic run_pass(logic conv, logic alg_on);
    cfg_type c [16];
    logic [15:0] m;
    logic [31:0] v;
    sample_type e;
    int i;
    m = 16'($random(seed));
    for (i = 0; i < 16; i++) begin
      v = $random(seed);
      aes_v[i] <= 24'($random(seed));
      exp_v[i] <= 24'($random(seed));
      c[i].sel = (i == 0) ? 5'h1F : (i == 15) ? 5'h10 : v[4:0];
      c[i].alg = alg_on ? dither_alg_type'(i % 4) : ALG_OFF;
      c[i].depth = alg_on ? DEPTH_16 : depth_type'(v[9:8]);
      wr(8'(`RIR_OFS_CFG + 4 * i), {18'h0, c[i].depth, 2'h0, c[i].alg, 3'h0, c[i].sel},
        `RIR_RESP_OKAY);
    end
    wr(`RIR_OFS_MUTE, {16'h0, m}, `RIR_RESP_OKAY);
    wr(`RIR_OFS_CTRL, {31'h0, conv}, `RIR_RESP_OKAY);
    // Converted inputs need a word clock edge, then one frame to reach the bus, then one more
    wait_frame(4);
    check("frame gap", gap, `RIR_FRAME_DIV);
    for (i = 0; i < 16; i++) begin
      e = expect_rec(c[i].sel[4] ? exp_v[c[i].sel[3:0]] : aes_v[c[i].sel[3:0]], m[i],
        c[i].depth);
      if (c[i].alg != ALG_OFF) begin
        check("dither low bits", {24'h0, REC_BUS[i][7:0]}, 32'h0);
      end else begin
        check("record channel", 32'(REC_BUS[i]), 32'(e));
        check("monitor channel", 32'(MON_REC_BUS[i]), 32'(e));
        if (i % 2 == 0) check("device left", 32'(REC_DEVICE[i / 2].left), 32'(e));
        else check("device right", 32'(REC_DEVICE[i / 2].right), 32'(e));
      end
    end
    if (!alg_on) begin
      e = expect_rec(exp_v[15], m[0], c[0].depth);
      e = e < 0 ? -e : e;
      // Clearing read holds everything since the last clear, so at least this level
      rd(`RIR_OFS_PEAK, {8'h0, e}, `RIR_RESP_OKAY, 1'b1);
      wait_frame(2);
      rd(`RIR_OFS_PEAK, {8'h0, e}, `RIR_RESP_OKAY);
    end
  endtask

  initial begin
    RST = 1'b1;
    HOST_PLAY = '0;
    HOST_PLAY_VALID = 1'b0;
    aes_v = '0;
    exp_v = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = '0;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    repeat (20) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    check("reset clock source", CLK_SRC, 32'h0);
    check("reset level", OUT_LEVEL, 32'hFF);
    rd(`RIR_OFS_MUTE, 32'h0, `RIR_RESP_OKAY);
    rd(8'(`RIR_OFS_CFG + 20), 32'h5, `RIR_RESP_OKAY);
    rd(8'h20, 32'h0, `RIR_RESP_DECERR);
    wr(8'hC4, 32'hFFFF_FFFF, `RIR_RESP_DECERR);
    wr(`RIR_OFS_STATUS, 32'hFFFF_FFFF, `RIR_RESP_OKAY);
    wr(`RIR_OFS_CTRL, 32'h50, `RIR_RESP_OKAY);
    wr(`RIR_OFS_LEVEL, 32'h3C, `RIR_RESP_OKAY);
    wr(`RIR_OFS_MUTE, 32'hFFFF, `RIR_RESP_OKAY);
    check("clock source", CLK_SRC, 32'h5);
    check("level", OUT_LEVEL, 32'h3C);
    wr(`RIR_OFS_CTRL, 32'h52, `RIR_RESP_OKAY);
    check("restored clock source", CLK_SRC, 32'h0);
    check("restored level", OUT_LEVEL, 32'hFF);
    rd(`RIR_OFS_MUTE, 32'h0, `RIR_RESP_OKAY);
    rd(`RIR_OFS_CTRL, 32'h0, `RIR_RESP_OKAY);
    repeat (3) begin
      @(posedge REF_CLK);
      foreach (HOST_PLAY[k]) HOST_PLAY[k] <= {24'($random(seed)), 24'($random(seed))};
      HOST_PLAY_VALID <= 1'b1;
      @(posedge REF_CLK);
      HOST_PLAY_VALID <= 1'b0;
      @(posedge REF_CLK);
      check("play valid", PLAY_VALID, 32'h1);
      for (int k = 0; k < 8; k++) begin
        check("play left", 32'(PLAY_BUS[2 * k]), 32'(HOST_PLAY[k].left));
        check("play right", 32'(PLAY_BUS[2 * k + 1]), 32'(HOST_PLAY[k].right));
      end
      @(posedge REF_CLK);
      check("play valid end", PLAY_VALID, 32'h0);
    end
    run_pass(1'b0, 1'b0);
    run_pass(1'b1, 1'b0);
    run_pass(1'b1, 1'b1);
    report_and_stop();
  end
endmodule
